// ==== logic/eeprom_map.svh ====
// constants of the serial eeprom command block: opcodes, field sizes, timing
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// opcode field after the start bit
`define OPC_READ       2'h2
`define OPC_WRITE      2'h1
`define OPC_ERASE      2'h3
`define OPC_CTRL       2'h0

// top two address bits under the control opcode
`define CTL_ENABLE     2'h3
`define CTL_DISABLE    2'h0
`define CTL_FILL       2'h1
`define CTL_ERASE_ALL  2'h2

// frame layout: opcode, address, data, counted after the start bit
`define HDR_BITS       5'h0A
`define FULL_BITS      5'h1A
`define ADDR_BITS      7
`define WORD_BITS      16
`define WORDS          128
`define ERASED_WORD    16'hFFFF
`define PAD_DATA       16'h0000

// timing
`define CLK_PERIOD_NS      50
`define PROG_CYCLE_TIME_US 10
`define PROG_CYCLES        (`PROG_CYCLE_TIME_US * 1000 / `CLK_PERIOD_NS)

`endif

// ==== logic/eeprom_pkg.sv ====
// types and command decode shared by the eeprom command block
`include "eeprom_map.svh"
package eeprom_pkg;

  typedef enum logic [2:0] {
    read_word_cmd         = 3'h0,
    write_word_cmd        = 3'h1,
    erase_word_cmd        = 3'h2,
    program_enable_cmd    = 3'h3,
    program_disable_cmd   = 3'h4,
    fill_whole_array_cmd  = 3'h5,
    erase_whole_array_cmd = 3'h6
  } cmd_kind_t;

  typedef enum logic [1:0] {
    st_idle = 2'h1,
    st_busy = 2'h2
  } prog_state_t;

  function automatic cmd_kind_t decode_cmd(input logic [1:0] opc, input logic [1:0] top);
    cmd_kind_t k;
    k = read_word_cmd;
    case (opc)
      `OPC_READ:  k = read_word_cmd;
      `OPC_WRITE: k = write_word_cmd;
      `OPC_ERASE: k = erase_word_cmd;
      default: begin
        case (top)
          `CTL_ENABLE:    k = program_enable_cmd;
          `CTL_FILL:      k = fill_whole_array_cmd;
          `CTL_ERASE_ALL: k = erase_whole_array_cmd;
          default:        k = program_disable_cmd;
        endcase
      end
    endcase
    return k;
  endfunction

  function automatic logic carries_data(input cmd_kind_t k);
    return (k == write_word_cmd) || (k == fill_whole_array_cmd);
  endfunction

endpackage

// ==== logic/prog_port_if.sv ====
// carrier between the sequencer and the cell array
`timescale 1ns/1ps
`include "eeprom_map.svh"
interface prog_port_if;
  logic                        go;
  eeprom_pkg::cmd_kind_t       kind;
  logic [`ADDR_BITS-1:0]       addr;
  logic [`WORD_BITS-1:0]       data;
  logic [`ADDR_BITS-1:0]       peek_addr;
  logic [`WORD_BITS-1:0]       peek_data;

  modport ctrl  (output go, kind, addr, data, peek_addr, input peek_data);
  modport cells (input go, kind, addr, data, peek_addr, output peek_data);
endinterface

// ==== logic/cell_array.sv ====
// flip-flop cell array, changed at the end of each programming cycle
`timescale 1ns/1ps
`include "eeprom_map.svh"
module cell_array #(
  parameter int unsigned WORDS = `WORDS,
  parameter int unsigned WIDTH = `WORD_BITS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  prog_port_if.cells pp
);

  if (WORDS < 1 || WORDS > `WORDS || WIDTH != `WORD_BITS) begin : g_bad_size
    $error("cell_array: size not served by a 7-bit address and 16-bit word");
  end

  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            peek;
  } cells_t;

  cells_t r;
  cells_t nxt;

  always_comb begin
    nxt      = r;
    nxt.peek = r.mem[pp.peek_addr];
    if (pp.go) begin
      case (pp.kind)
        eeprom_pkg::erase_word_cmd:        nxt.mem[pp.addr] = `ERASED_WORD;
        eeprom_pkg::write_word_cmd:        nxt.mem[pp.addr] = pp.data;
        eeprom_pkg::erase_whole_array_cmd: begin
          for (int i = 0; i < WORDS; i++) nxt.mem[i] = `ERASED_WORD;
        end
        eeprom_pkg::fill_whole_array_cmd: begin
          for (int i = 0; i < WORDS; i++) nxt.mem[i] = pp.data;
        end
        default: ;
      endcase
    end
  end

  // cells come up erased
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) r <= '1;
    else        r <= nxt;
  end

  assign pp.peek_data = r.peek;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_erase_word_ones: assert property (pp.go && pp.kind == eeprom_pkg::erase_word_cmd
    |=> r.mem[$past(pp.addr)] == `ERASED_WORD)
    else $error("erased word not all ones");
  a_erase_all_ones: assert property (pp.go && pp.kind == eeprom_pkg::erase_whole_array_cmd
    |=> r.mem[0] == `ERASED_WORD && r.mem[WORDS-1] == `ERASED_WORD)
    else $error("array not all ones after erase all");
  a_write_no_erase: assert property (pp.go && pp.kind == eeprom_pkg::write_word_cmd
    |=> r.mem[$past(pp.addr)] == $past(pp.data))
    else $error("word write did not land");

endmodule

// ==== logic/serial_eeprom_erase_status_ctrl.sv ====
// serial eeprom command sequencer: link shifter and programming control
`timescale 1ns/1ps
`include "eeprom_map.svh"

// ----------------------------------------------------------------
// link side shifter, clocked by the host's serial clock
// ----------------------------------------------------------------
module link_shifter (
  input  wire logic        shift_clk,
  input  wire logic        rst_n,
  input  wire logic        cs,
  input  wire logic        si,
  output logic [25:0]      word,
  output logic             tgl,
  output logic             started
);

  typedef struct packed {
    logic        started;
    logic        done;
    logic [4:0]  cnt;
    logic [25:0] sr;
  } frame_t;

  typedef struct packed {
    logic        tgl;
    logic [25:0] word;
  } handoff_t;

  frame_t                f_r;
  frame_t                f_nxt;
  handoff_t              h_r;
  handoff_t              h_nxt;
  logic [25:0]           sr_n;
  logic [4:0]            cnt_n;
  eeprom_pkg::cmd_kind_t k;
  logic                  fin;
  wire logic             frame_rst_n;

  // the serial clock stops between frames, so the frame itself is ended
  // by deselect; a glitch-free chip select is assumed for this reset
  assign frame_rst_n = rst_n & cs;

  always_comb begin
    f_nxt = f_r;
    h_nxt = h_r;
    sr_n  = {f_r.sr[24:0], si};
    cnt_n = f_r.cnt + 5'h01;
    k     = eeprom_pkg::decode_cmd(sr_n[9:8], sr_n[7:6]);
    fin   = 1'b0;
    if (!f_r.started) begin
      f_nxt.started = si;
    end else if (!f_r.done) begin
      f_nxt.sr  = sr_n;
      f_nxt.cnt = cnt_n;
      if ((cnt_n == `HDR_BITS && !eeprom_pkg::carries_data(k)) || cnt_n == `FULL_BITS) begin
        fin = 1'b1;
      end
    end
    if (fin) begin
      f_nxt.done = 1'b1;
      h_nxt.tgl  = ~h_r.tgl;
      // short frames are left aligned so the header sits at the same bits
      h_nxt.word = (cnt_n == `HDR_BITS) ? {sr_n[9:0], `PAD_DATA} : sr_n;
    end
  end

  always_ff @(posedge shift_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) f_r <= '0;
    else              f_r <= f_nxt;
  end

  // the handoff survives deselect: the other side reads it after the toggle
  always_ff @(posedge shift_clk or negedge rst_n) begin
    if (!rst_n) h_r <= '0;
    else        h_r <= h_nxt;
  end

  assign word    = h_r.word;
  assign tgl     = h_r.tgl;
  assign started = f_r.started;

endmodule

// ----------------------------------------------------------------
// top: synchronisers, command execution, timer, status output
// ----------------------------------------------------------------
module serial_eeprom_erase_status_ctrl #(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  serial_shift_clock,
  input  wire logic                  chip_select,
  input  wire logic                  serial_in_line,
  output logic                       serial_out,
  output logic                       serial_out_oe,
  output logic                       prog_busy,
  input  wire logic [`ADDR_BITS-1:0] peek_addr,
  output logic [`WORD_BITS-1:0]      peek_data
);

  localparam int unsigned TW = $clog2(PROG_CYCLES + 1);

  if (PROG_CYCLES < 2) begin : g_bad_time
    $error("PROG_CYCLES must be at least two");
  end

  typedef struct packed {
    logic                    cs_s1;
    logic                    cs_s2;
    logic                    cs_s3;
    logic                    tg_s1;
    logic                    tg_s2;
    logic                    tg_s3;
    logic                    st_s1;
    logic                    st_s2;
    logic                    pend;
    logic [25:0]             cmd;
    logic                    we;
    eeprom_pkg::prog_state_t state;
    logic                    busy;
    logic [TW-1:0]           timer;
    logic                    armed;
    logic                    go;
    eeprom_pkg::cmd_kind_t   kind;
    logic [`ADDR_BITS-1:0]   addr;
    logic [`WORD_BITS-1:0]   data;
    logic                    dout;
    logic                    dout_oe;
  } ctrl_t;

  ctrl_t                 r;
  ctrl_t                 n;
  logic [25:0]           l_word;
  logic                  l_tgl;
  logic                  l_started;
  logic                  tg_chg;
  logic                  cs_fall;
  logic                  have;
  logic [25:0]           w;
  eeprom_pkg::cmd_kind_t kind;
  logic                  clr_ready;

  prog_port_if pp ();

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  link_shifter u_link (
    .shift_clk (serial_shift_clock),
    .rst_n   (rst_n),
    .cs      (chip_select),
    .si      (serial_in_line),
    .word    (l_word),
    .tgl     (l_tgl),
    .started (l_started)
  );

  // ----------------------------------------------------------------
  // cells
  // ----------------------------------------------------------------
  cell_array #(
    .WORDS (`WORDS),
    .WIDTH (`WORD_BITS)
  ) u_cells (
    .clk   (clk),
    .rst_n (rst_n),
    .pp    (pp)
  );

  assign pp.go        = r.go;
  assign pp.kind      = r.kind;
  assign pp.addr      = r.addr;
  assign pp.data      = r.data;
  assign pp.peek_addr = peek_addr;
  assign peek_data    = pp.peek_data;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  // chip select and toggle take the same number of stages, so a completed
  // frame is never seen after the deselect that ends it
  assign tg_chg    = r.tg_s2 ^ r.tg_s3;
  assign cs_fall   = r.cs_s3 & ~r.cs_s2;
  assign have      = r.pend | tg_chg;
  assign w         = tg_chg ? l_word : r.cmd;
  assign kind      = eeprom_pkg::decode_cmd(w[25:24], w[23:22]);
  assign clr_ready = r.armed & ~r.busy & r.st_s2 & r.cs_s2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = r;
    n.cs_s1 = chip_select;
    n.cs_s2 = r.cs_s1;
    n.cs_s3 = r.cs_s2;
    n.tg_s1 = l_tgl;
    n.tg_s2 = r.tg_s1;
    n.tg_s3 = r.tg_s2;
    n.st_s1 = l_started;
    n.st_s2 = r.st_s1;
    n.go    = 1'b0;

    // the word is stable once its toggle has crossed
    if (tg_chg) begin
      n.pend = 1'b1;
      n.cmd  = l_word;
    end
    if (!r.cs_s2) begin
      n.pend = 1'b0;
    end

    if (clr_ready) begin
      n.armed = 1'b0;
    end

    case (r.state)
      eeprom_pkg::st_idle: begin
        if (cs_fall && have) begin
          case (kind)
            eeprom_pkg::program_enable_cmd:  n.we = 1'b1;
            eeprom_pkg::program_disable_cmd: n.we = 1'b0;
            eeprom_pkg::read_word_cmd:       ;
            default: begin
              // programming kinds only; refused silently when disabled
              if (r.we) begin
                n.state = eeprom_pkg::st_busy;
                n.busy  = 1'b1;
                n.timer = PROG_CYCLES[TW-1:0];
                n.armed = 1'b1;
                n.kind  = kind;
                n.addr  = w[22:16];
                n.data  = w[15:0];
              end
            end
          endcase
        end
      end
      eeprom_pkg::st_busy: begin
        // chip select is not looked at here, so polling cannot abort
        if (r.timer == TW'(1)) begin
          n.go    = 1'b1;
          n.state = eeprom_pkg::st_idle;
          n.busy  = 1'b0;
        end else begin
          n.timer = r.timer - TW'(1);
        end
      end
      default: begin
        n.state = eeprom_pkg::st_idle;
        n.busy  = 1'b0;
      end
    endcase

    // output follows chip select a few cycles late; a limitation of syncing
    n.dout_oe = r.cs_s2 & n.armed;
    n.dout    = ~n.busy;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.state <= eeprom_pkg::st_idle;
      r.kind  <= eeprom_pkg::read_word_cmd;
      r.dout  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign serial_out    = r.dout;
  assign serial_out_oe = r.dout_oe;
  assign prog_busy     = r.busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TW:0] bc_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      bc_r <= '0;
    else if (r.busy) bc_r <= bc_r + (TW+1)'(1);
    else             bc_r <= '0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence prog_request;
    cs_fall && have && r.state == eeprom_pkg::st_idle && r.we &&
      (kind == eeprom_pkg::erase_word_cmd || kind == eeprom_pkg::erase_whole_array_cmd);
  endsequence

  sequence ready_cleared;
    clr_ready ##1 !r.armed;
  endsequence

  a_start_on_fall: assert property (prog_request |=> prog_busy ##0 r.timer == PROG_CYCLES[TW-1:0])
    else $error("programming did not start on deselect");
  a_enable_needed: assert property ($rose(prog_busy) |-> $past(r.we))
    else $error("programming started while disabled");
  a_busy_length: assert property ($fell(prog_busy) |-> bc_r == (TW+1)'(PROG_CYCLES))
    else $error("programming time wrong");
  a_poll_no_abort: assert property (prog_busy && r.timer != TW'(1) |=> prog_busy && !r.go)
    else $error("programming cut short");
  a_status_level: assert property (serial_out_oe |-> serial_out == !prog_busy)
    else $error("status level wrong");
  a_float_deselect: assert property (!r.cs_s2 |=> !serial_out_oe)
    else $error("output driven while deselected");
  a_ready_clear: assert property (ready_cleared |=> !serial_out_oe)
    else $error("ready not cleared by start bit");
  a_idle_deselect: assert property (!r.cs_s2 ##1 !r.cs_s2 |-> !r.pend)
    else $error("pending command survived deselect");

  sequence refused_request;
    cs_fall && have && r.state == eeprom_pkg::st_idle && !r.we &&
      kind != eeprom_pkg::program_enable_cmd && kind != eeprom_pkg::program_disable_cmd;
  endsequence

  a_refuse_disabled: assert property (refused_request |=> !prog_busy)
    else $error("programming accepted while disabled");
  a_clear_float: assert property (clr_ready |=> !serial_out_oe)
    else $error("output still driven after start bit");
  a_busy_ignores: assert property (prog_busy && cs_fall && have |=> r.we == $past(r.we))
    else $error("command accepted while busy");

endmodule

// ==== dv/host_link_model.sv ====
// host side model driving the serial link of the command block
`timescale 1ns/1ps
module host_link_model (
  output logic serial_shift_clock,
  output logic chip_select,
  output logic serial_in_line
);
  // ----------------------------------------------------------------
  // link clock of 160 ns, standing still between frames
  // ----------------------------------------------------------------
  localparam int HALF_NS = 80;

  initial begin
    serial_shift_clock = 1'h0;
    chip_select        = 1'h0;
    serial_in_line     = 1'h0;
  end

  // a released data line shows the inverse, never a stale value
  task automatic select(input logic v);
    if (v && !chip_select) #250;
    chip_select = v;
    if (!v) serial_in_line = ~serial_in_line;
  endtask

  // odd offset keeps the link unrelated in phase to clk
  task automatic send(input logic [26:0] bits, input int n, input logic hold);
    if (!chip_select) begin
      select(1'h1);
      #37;
    end
    for (int i = n - 1; i >= 0; i--) begin  // msb first
      serial_in_line = bits[i];
      #HALF_NS serial_shift_clock = 1'h1;
      #HALF_NS serial_shift_clock = 1'h0;
    end
    #20;
    if (!hold) select(1'h0);  // deselect before the next clock rise
  endtask
endmodule

// ==== dv/serial_eeprom_erase_status_ctrl_tb_top.sv ====
// self-checking bench of the serial eeprom command block
`timescale 1ns/1ps
`include "eeprom_map.svh"
module serial_eeprom_erase_status_ctrl_tb_top;
  // short programming time keeps the run brief
  localparam int PC = 120;
  logic                  clk;
  logic                  rst_n;
  logic                  lclk;
  logic                  cs;
  logic                  si;
  logic                  so;
  logic                  so_oe;
  logic                  busy;
  logic [`ADDR_BITS-1:0] peek_addr;
  logic [`WORD_BITS-1:0] peek_data;
  int                    failures;
  int                    num_checks;
  int                    len;

  host_link_model i_host (
    .serial_shift_clock(lclk), .chip_select(cs), .serial_in_line(si)
  );

  serial_eeprom_erase_status_ctrl #(.PROG_CYCLES(PC)) i_dut (
    .clk(clk), .rst_n(rst_n), .serial_shift_clock(lclk), .chip_select(cs),
    .serial_in_line(si), .serial_out(so), .serial_out_oe(so_oe), .prog_busy(busy),
    .peek_addr(peek_addr), .peek_data(peek_data)
  );

  initial clk = 1'h0;
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t ns: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // length of the next busy period in clk cycles, zero if none starts
  task automatic busy_run(output int n);
    n = 0;
    for (int k = 0; k < 12 && busy !== 1'h1; k++) tick(1);
    while (busy === 1'h1 && n < 4 * PC) begin
      n++;
      tick(1);
    end
    if (n >= 4 * PC) begin
      failures++;
      test_done();
    end
  endtask

  task automatic peek_chk(input logic [6:0] a, input logic [15:0] exp);
    tick(1);
    peek_addr = a;
    tick(2);
    check(peek_data, exp, "array word");
  endtask

  task automatic short_cmd(input logic [1:0] opc, input logic [7:0] a, input logic hold);
    i_host.send({16'h0000, 1'h1, opc, a}, 11, hold);
  endtask

  task automatic data_cmd(input logic [1:0] opc, input logic [7:0] a, input logic [15:0] d);
    i_host.send({1'h1, opc, a, d}, 27, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_locked();
    logic [9:0] tbl [5];
    tbl = '{10'h105, 10'h040, 10'h305, 10'h080, 10'h205};
    check(so_oe, 1'h0, "oe after reset");
    check(busy, 1'h0, "busy after reset");
    for (int i = 0; i < 5; i++) begin
      if (i < 2) data_cmd(tbl[i][9:8], tbl[i][7:0], 16'h0000);
      else short_cmd(tbl[i][9:8], tbl[i][7:0], 1'h0);
      busy_run(len);
      check(16'(len), 16'h0000, "refused while disabled");
    end
    peek_chk(7'h05, 16'hFFFF);
    $display("test_locked done");
  endtask

  task automatic test_write_poll();
    short_cmd(2'h0, 8'hC0, 1'h0);
    data_cmd(2'h1, 8'h05, 16'h1234);
    fork
      busy_run(len);
      begin
        tick(8);
        repeat (2) begin
          i_host.select(1'h1);
          tick(4);
          check(so_oe, 1'h1, "status driven");
          check(so, 1'h0, "busy shown");
          i_host.select(1'h0);
          tick(4);
          check(so_oe, 1'h0, "float when deselected");
        end
      end
    join
    check(16'(len), 16'(PC), "busy length with polling");
    i_host.select(1'h1);
    tick(4);
    check(so, 1'h1, "ready shown");
    i_host.send(27'h0000001, 1, 1'h1);
    tick(6);
    check(so_oe, 1'h0, "ready cleared by start bit");
    i_host.select(1'h0);
    peek_chk(7'h05, 16'h1234);
    peek_chk(7'h04, 16'hFFFF);
    $display("test_write_poll done");
  endtask

  // a write issued mid-erase must be dropped, so the word ends erased
  task automatic test_erase_refuse();
    short_cmd(2'h3, 8'h05, 1'h0);
    fork
      busy_run(len);
      begin
        tick(6);
        data_cmd(2'h1, 8'h05, 16'h0000);
      end
    join
    check(16'(len), 16'(PC), "erase busy length");
    busy_run(len);
    check(16'(len), 16'h0000, "command during busy");
    peek_chk(7'h05, 16'hFFFF);
    $display("test_erase_refuse done");
  endtask

  task automatic test_array_ops();
    data_cmd(2'h0, 8'h40, 16'hA5A5);
    busy_run(len);  // next frame only after ready
    check(16'(len), 16'(PC), "fill busy length");
    peek_chk(7'h00, 16'hA5A5);
    peek_chk(7'h7F, 16'hA5A5);
    short_cmd(2'h0, 8'h80, 1'h0);
    busy_run(len);
    check(16'(len), 16'(PC), "erase all busy length");
    peek_chk(7'h00, 16'hFFFF);
    peek_chk(7'h7F, 16'hFFFF);
    i_host.select(1'h1);
    tick(4);
    check(so, 1'h1, "ready after erase all");
    short_cmd(2'h0, 8'h00, 1'h0);  // clearing start bit opens the disable
    data_cmd(2'h1, 8'h09, 16'h0000);
    busy_run(len);
    check(16'(len), 16'h0000, "write after disable");
    peek_chk(7'h09, 16'hFFFF);
    $display("test_array_ops done");
  endtask

  initial begin
    failures = 0;
    num_checks = 0;
    len = 0;
    rst_n = 1'h0;
    peek_addr = 7'h00;
    repeat (12) @(posedge clk);
    #2 rst_n = 1'h1;
    tick(4);
    test_locked();
    test_write_poll();
    test_erase_refuse();
    test_array_ops();
    test_done();
  end
endmodule
